//--- output_ctrl_regs.sv
`timescale 1ns/10ps
// Configuration register bank of the converter output path.
module output_ctrl_regs (
  input  wire logic                       clk_in,
  input  wire logic                       srst_in,
  input  wire logic                       wr_en_in,
  input  wire logic                       rd_en_in,
  input  wire logic [cfg_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [cfg_pkg::DATA_W-1:0] wdata_in,
  input  wire logic [2:0]                 grade_rate_in,
  input  wire logic [1:0]                 grade_res_in,
  output logic      [cfg_pkg::DATA_W-1:0] rdata_out,
  output logic                            rvalid_out,
  output logic                            chop_en_out,
  output logic                            reduced_link_out,
  output logic                            invert_out,
  output logic                            twos_comp_out,
  output logic      [1:0]                 termination_out,
  output logic      [1:0]                 drive_current_out,
  output logic                            fco_double_out,
  output logic                            dco_double_out,
  output logic      [2:0]                 in_phase_out,
  output logic      [3:0]                 out_phase_out,
  output logic      [2:0]                 rate_out,
  output logic      [1:0]                 res_out,
  output logic                            chip_pdwn_out,
  output logic                            pulldown_off_out,
  output logic                            vcm_pdwn_out,
  output logic                            dp_reset_out,
  output logic                            init_busy_out
);
  import cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Storage.
  logic [7:0] index_reg;                 // Clock output channel select.
  logic [7:0] power_reg;                 // Power mode control.
  logic [7:0] divider_reg;               // Input clock divider ratio.
  logic [7:0] enhancement_control;       // Chop control.
  logic [7:0] output_link_mode;          // Link, invert and format.
  logic [7:0] output_driver_adjust;      // Termination and drive.
  logic [7:0] clock_phase_adjust;        // Input and output clock phase.
  logic [7:0] rate_resolution_override;  // Staged grade override.
  logic [7:0] io_pulldown_control;       // Serial pin pull-down control.
  logic [7:0] reference_power_control;   // Reference generator control.
  logic [7:0] active_override;           // Override after transfer.
  logic       restart;                   // Digital reset entry pulse.
  logic       init_busy;                 // Sequencer still running.
  cfg_bus_if  bus ();                    // Timer to bank link.

  ////////////////////////////////////////////////////////////////////////
  // Decoding.
  // Returns high when the address equals the given target.
  function automatic logic hit(input logic [8:0] a, input logic [8:0] target);
    hit = (a == target);
  endfunction

  wire        wr_index    = wr_en_in && hit(addr_in, ADDR_INDEX);
  wire        wr_power    = wr_en_in && hit(addr_in, ADDR_POWER);
  wire        wr_divider  = wr_en_in && hit(addr_in, ADDR_DIVIDER);
  wire        wr_enhance  = wr_en_in && hit(addr_in, ADDR_ENHANCE);
  wire        wr_link     = wr_en_in && hit(addr_in, ADDR_LINK);
  wire        wr_driver   = wr_en_in && hit(addr_in, ADDR_DRIVER);
  wire        wr_phase    = wr_en_in && hit(addr_in, ADDR_PHASE);
  wire        wr_transfer = wr_en_in && hit(addr_in, ADDR_TRANSFER);
  wire        wr_override = wr_en_in && hit(addr_in, ADDR_OVERRIDE);
  wire        wr_pulldown = wr_en_in && hit(addr_in, ADDR_PULLDOWN);
  wire        wr_refpwr   = wr_en_in && hit(addr_in, ADDR_REFPWR);
  wire [1:0]  next_mode   = wdata_in[1:0] & MASK_POWER[1:0];
  wire        in_reset    = (power_reg[1:0] == PWR_RESET);
  wire        do_transfer = wr_transfer && wdata_in[BIT_TRANSFER];
  wire [7:0]  read_mux;

  // Read selection; open bits are already zero in storage.
  assign read_mux =
      hit(addr_in, ADDR_INDEX)    ? index_reg :
      hit(addr_in, ADDR_POWER)    ? power_reg :
      hit(addr_in, ADDR_DIVIDER)  ? divider_reg :
      hit(addr_in, ADDR_ENHANCE)  ? enhancement_control :
      hit(addr_in, ADDR_LINK)     ? output_link_mode :
      hit(addr_in, ADDR_DRIVER)   ? output_driver_adjust :
      hit(addr_in, ADDR_PHASE)    ? clock_phase_adjust :
      hit(addr_in, ADDR_OVERRIDE) ? rate_resolution_override :
      hit(addr_in, ADDR_PULLDOWN) ? io_pulldown_control :
      hit(addr_in, ADDR_REFPWR)   ? reference_power_control : RST_ZERO;

  ////////////////////////////////////////////////////////////////////////
  // Register writes; the serial port is never reset by a digital reset.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      index_reg                <= RST_ZERO;
      power_reg                <= RST_ZERO;
      divider_reg              <= RST_ZERO;
      enhancement_control      <= RST_ZERO;
      output_link_mode         <= RST_LINK; // (R5)
      output_driver_adjust     <= RST_ZERO;
      clock_phase_adjust       <= RST_PHASE;
      rate_resolution_override <= RST_ZERO;
      io_pulldown_control      <= RST_ZERO;
      reference_power_control  <= RST_ZERO;
    end else begin
      // Every write below lands at once and masks open bits.
      if (wr_index)    index_reg            <= wdata_in & MASK_INDEX;    // (R20) (R21)
      if (wr_power)    power_reg            <= wdata_in & MASK_POWER;    // (R19)
      if (wr_divider)  divider_reg          <= wdata_in & MASK_DIVIDER;
      if (wr_enhance)  enhancement_control  <= wdata_in & MASK_ENHANCE;
      if (wr_link)     output_link_mode     <= wdata_in & MASK_LINK;
      if (wr_driver)   output_driver_adjust <= wdata_in & MASK_DRIVER;
      if (wr_phase)    clock_phase_adjust   <= wdata_in & MASK_PHASE;
      if (wr_override) rate_resolution_override <= wdata_in & MASK_OVERRIDE;
      if (wr_pulldown) io_pulldown_control  <= wdata_in & MASK_PULLDOWN;
      if (wr_refpwr)   reference_power_control <= wdata_in & MASK_REFPWR;
    end
  end

  // The override is copied only on a transfer strobe.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      active_override <= RST_ZERO;
    end else if (do_transfer) begin
      active_override <= rate_resolution_override; // (R13)
    end
  end

  // A digital reset entry restarts the initialization sequence.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      restart <= 1'b0;
    end else begin
      restart <= wr_power && (next_mode == PWR_RESET) && !in_reset; // (R17)
    end
  end

  init_seq u_init (
    .clk_in     (clk_in),
    .srst_in    (srst_in),
    .restart_in (restart),
    .busy_out   (init_busy)
  );

  assign bus.dp_reset = in_reset;

  frame_timer u_timer (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .bus     (bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // Derived controls.
  wire        ovr_en     = active_override[BIT_OVR_EN];
  wire [2:0]  ovr_rate   = active_override[2:0];
  wire [1:0]  ovr_res    = active_override[OVR_RES_LO+1:OVR_RES_LO];
  // Higher rate code or a 14-bit request on a 12-bit part is an upgrade.
  wire        upgrade    = ovr_en && ((ovr_rate > grade_rate_in) ||
                           ((ovr_res == RES_14) && (grade_res_in == RES_12)));
  wire [1:0]  term_sel   = output_driver_adjust[TERM_LO+1:TERM_LO];
  // Termination overrides double drive on the clock outputs.
  wire        double_req = output_driver_adjust[BIT_DRIVE] && (term_sel == 2'b00); // (R8)
  wire [3:0]  out_ph_req = clock_phase_adjust[3:0];
  // Out-of-range phase codes keep the previous legal value.
  wire        out_ph_ok  = (out_ph_req <= OUTPH_MAX); // (R11)
  wire        use_div    = (divider_reg[2:0] != 3'b000);
  wire [2:0]  in_ph_req  = use_div ? clock_phase_adjust[INPH_LO+2:INPH_LO] : 3'b000; // (R9)
  wire        link_sel   = output_link_mode[BIT_LINK_STD];
  // Current codes: 01 standard swing, 10 reduced swing.
  wire [1:0]  cur_sel    = link_sel ? 2'b10 : 2'b01; // (R3)

  ////////////////////////////////////////////////////////////////////////
  // Outputs that may change at any time.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      chop_en_out       <= 1'b0;
      reduced_link_out  <= 1'b0;
      invert_out        <= 1'b0;
      twos_comp_out     <= 1'b1;
      termination_out   <= 2'b00;
      drive_current_out <= 2'b01;
      pulldown_off_out  <= 1'b0;
      vcm_pdwn_out      <= 1'b0;
      dp_reset_out      <= 1'b0;
      init_busy_out     <= 1'b1;
      chip_pdwn_out     <= 1'b0;
      rate_out          <= 3'b000;
      res_out           <= 2'b00;
    end else begin
      chop_en_out       <= enhancement_control[BIT_CHOP];            // (R1)
      reduced_link_out  <= link_sel;                                 // (R2)
      invert_out        <= output_link_mode[BIT_INVERT];             // (R4)
      twos_comp_out     <= output_link_mode[BIT_FORMAT];             // (R5)
      termination_out   <= term_sel;                                 // (R6)
      drive_current_out <= cur_sel;                                  // (R3)
      pulldown_off_out  <= io_pulldown_control[BIT_PULLDOWN];        // (R14)
      vcm_pdwn_out      <= reference_power_control[BIT_REFPWR];      // (R15)
      dp_reset_out      <= in_reset || init_busy;                    // (R19) (R16)
      init_busy_out     <= init_busy;
      chip_pdwn_out     <= upgrade;                                  // (R12)
      rate_out          <= ovr_en ? ovr_rate : grade_rate_in;
      res_out           <= ovr_en ? ovr_res : grade_res_in;
    end
  end

  // Phase and drive settings wait for a frame boundary, except in reset mode.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      fco_double_out <= 1'b0;
      dco_double_out <= 1'b0;
      in_phase_out   <= 3'b000;
      out_phase_out  <= RST_PHASE[3:0];
    end else if (bus.frame_edge || in_reset) begin // (R22)
      fco_double_out <= double_req && index_reg[BIT_FCO_SEL]; // (R7)
      dco_double_out <= double_req && index_reg[BIT_DCO_SEL]; // (R7)
      in_phase_out   <= in_ph_req;
      if (out_ph_ok) out_phase_out <= out_ph_req;
    end
  end

  // Read data is registered one cycle after the read strobe.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_out  <= RST_ZERO;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= rd_en_in;
      rdata_out  <= rd_en_in ? read_mux : RST_ZERO; // (R21)
    end
  end
endmodule

//--- cfg_pkg.sv
// Overview of operation
// (R1) Chop bit enables first-stage chopping output
// (R2) Link bit set selects reduced-range link
// (R3) Driver current chosen automatically per link
// (R4) Invert bit inverts every serial output bit
// (R5) Format defaults twos complement, clear offset
// (R6) Two-bit field selects output termination
// (R7) Drive bit doubles selected clock drivers
// (R8) Termination wins over double drive
// (R9) Input phase delays sampling 0-7 cycles
// (R10) Host keeps input phase within divider
// (R11) Output phase steps sixty degrees per code
// (R12) Override upgrade beyond grade powers down
// (R13) Override applies only after transfer strobe
// (R14) Pull-down bit disables serial pin pull-down
// (R15) Reference bit powers down common-mode generator
// (R16) Power-on init sequence sets registers, biases
// (R17) Host reruns init by 0x03 then 0x00
// (R18) Host keeps serial port idle when critical
// (R19) Reset mode resets datapath, keeps port
// (R20) Other registers act immediately when written
// (R21) Open bits read zero, writes ignored
// (R22) Phase and drive change at frame boundary
package cfg_pkg;
  localparam int          ADDR_W        = 9;   // Register address width.
  localparam int          DATA_W        = 8;   // Register data width.
  localparam logic [8:0]  ADDR_INDEX    = 9'h005;
  localparam logic [8:0]  ADDR_POWER    = 9'h008;
  localparam logic [8:0]  ADDR_DIVIDER  = 9'h00B;
  localparam logic [8:0]  ADDR_ENHANCE  = 9'h00C;
  localparam logic [8:0]  ADDR_LINK     = 9'h014;
  localparam logic [8:0]  ADDR_DRIVER   = 9'h015;
  localparam logic [8:0]  ADDR_PHASE    = 9'h016;
  localparam logic [8:0]  ADDR_TRANSFER = 9'h0FF;
  localparam logic [8:0]  ADDR_OVERRIDE = 9'h100;
  localparam logic [8:0]  ADDR_PULLDOWN = 9'h101;
  localparam logic [8:0]  ADDR_REFPWR   = 9'h102;
  // Writable bit masks; open bits are cleared on write and read.
  localparam logic [7:0]  MASK_INDEX    = 8'h30;
  localparam logic [7:0]  MASK_POWER    = 8'h23;
  localparam logic [7:0]  MASK_DIVIDER  = 8'h07;
  localparam logic [7:0]  MASK_ENHANCE  = 8'h04;
  localparam logic [7:0]  MASK_LINK     = 8'h45;
  localparam logic [7:0]  MASK_DRIVER   = 8'h31;
  localparam logic [7:0]  MASK_PHASE    = 8'h7F;
  localparam logic [7:0]  MASK_OVERRIDE = 8'h77;
  localparam logic [7:0]  MASK_PULLDOWN = 8'h01;
  localparam logic [7:0]  MASK_REFPWR   = 8'h08;
  // Reset values.
  localparam logic [7:0]  RST_LINK      = 8'h01;
  localparam logic [7:0]  RST_PHASE     = 8'h03;
  localparam logic [7:0]  RST_ZERO      = 8'h00;
  // Field positions.
  localparam int          BIT_CHOP      = 2;
  localparam int          BIT_LINK_STD  = 6;
  localparam int          BIT_INVERT    = 2;
  localparam int          BIT_FORMAT    = 0;
  localparam int          BIT_DRIVE     = 0;
  localparam int          TERM_LO       = 4;
  localparam int          INPH_LO       = 4;
  localparam int          BIT_PULLDOWN  = 0;
  localparam int          BIT_REFPWR    = 3;
  localparam int          BIT_TRANSFER  = 0;
  localparam int          BIT_OVR_EN    = 6;
  localparam int          OVR_RES_LO    = 4;
  localparam int          BIT_FCO_SEL   = 5;
  localparam int          BIT_DCO_SEL   = 4;
  localparam logic [1:0]  PWR_NORMAL    = 2'b00;
  localparam logic [1:0]  PWR_RESET     = 2'b11;
  localparam logic [3:0]  OUTPH_MAX     = 4'hB;
  localparam logic [1:0]  RES_14        = 2'b01;
  localparam logic [1:0]  RES_12        = 2'b10;
  localparam int          INIT_CYCLES   = 16;  // Length of each power-on setup step.
  localparam int          FRAME_CYCLES  = 14;  // Serial word length in clocks.
  typedef enum logic [1:0] {
    INIT_BIAS = 2'b00,
    INIT_REGS = 2'b01,
    INIT_DONE = 2'b11
  } init_state_t;
endpackage

//--- cfg_bus_if.sv
`timescale 1ns/10ps
// Frame boundary pulse and datapath reset shared between the bank and the frame timer.
interface cfg_bus_if;
  logic       frame_edge;  // One-cycle pulse at each frame boundary.
  logic       dp_reset;    // Datapath held in reset.
  modport timer (output frame_edge, input dp_reset);
  modport bank  (input frame_edge, output dp_reset);
endinterface

//--- frame_timer.sv
`timescale 1ns/10ps
// Counts serial word length and marks frame boundaries.
module frame_timer (
  input  wire logic clk_in,
  input  wire logic srst_in,
  cfg_bus_if.timer  bus
);
  import cfg_pkg::*;
  logic [4:0] count;  // Clocks into the current frame.
  logic       at_end; // Last clock of the frame.
  assign at_end = (count == 5'(FRAME_CYCLES - 1));
  // Counter restarts while the datapath is reset.
  always_ff @(posedge clk_in) begin
    if (srst_in || bus.dp_reset) begin
      count <= 5'h00;
      bus.frame_edge <= 1'b0;
    end else begin
      count <= at_end ? 5'h00 : count + 5'h01;
      bus.frame_edge <= at_end;
    end
  end
endmodule

//--- init_seq.sv
`timescale 1ns/10ps
// Power-on initialization sequencer; restarted by a digital reset.
module init_seq (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic restart_in,
  output logic      busy_out
);
  import cfg_pkg::*;
  init_state_t state;      // Sequencer state.
  logic [4:0]  count;      // Cycles spent in the current step.
  logic        step_done;  // Current step has run its length.
  assign step_done = (count == 5'(INIT_CYCLES - 1));
  // Walks bias setup then register setup.
  always_ff @(posedge clk_in) begin
    if (srst_in || restart_in) begin
      state <= INIT_BIAS; // (R16)
      count <= 5'h00;
    end else begin
      count <= step_done ? 5'h00 : count + 5'h01;
      case (state)
        INIT_BIAS: if (step_done) state <= INIT_REGS;
        INIT_REGS: if (step_done) state <= INIT_DONE;
        default:   state <= INIT_DONE;
      endcase
    end
  end
  assign busy_out = (state != INIT_DONE);
endmodule

//--- output_ctrl_regs_properties.sv
`timescale 1ns/10ps
// Watches the register bank at its ports only.
module output_ctrl_checker
  import cfg_pkg::*;
(
  input wire logic                       clk_in, srst_in, wr_en_in, rd_en_in,
  input wire logic [cfg_pkg::ADDR_W-1:0] addr_in,
  input wire logic [cfg_pkg::DATA_W-1:0] wdata_in, rdata_out,
  input wire logic                       rvalid_out, chop_en_out, reduced_link_out,
  input wire logic                       invert_out, twos_comp_out, fco_double_out,
  input wire logic                       dco_double_out, chip_pdwn_out, pulldown_off_out,
  input wire logic                       vcm_pdwn_out, dp_reset_out,
  input wire logic [1:0]                 termination_out, drive_current_out, res_out,
  input wire logic [2:0]                 rate_out,
  input wire logic [3:0]                 out_phase_out
);
  logic [7:0] wd1, wd2;   // Write data delayed to line up with the output update.
  logic [4:0] term_cnt;   // Cycles that a nonzero termination has stood.
  wire wr_link = wr_en_in && addr_in == ADDR_LINK;
  wire wr_xfer = wr_en_in && addr_in == ADDR_TRANSFER && wdata_in[BIT_TRANSFER];
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  ////////////////////////////////////////////////////////////////////////////////
  // Delay line and termination age counter.
  always_ff @(posedge clk_in) begin
    wd1 <= wdata_in;
    wd2 <= wd1;
    if (srst_in || termination_out == 2'h0) term_cnt <= 5'h00;
    else if (term_cnt != 5'h1F) term_cnt <= term_cnt + 5'h01;
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_chop_follow: assert property (wr_en_in && addr_in == ADDR_ENHANCE |->
    ##2 chop_en_out == wd2[BIT_CHOP]) else $error("chop output wrong");
  a_link_follow: assert property (wr_link |-> ##2 reduced_link_out == wd2[6]
    && invert_out == wd2[2] && twos_comp_out == wd2[0] &&
    drive_current_out == (wd2[6] ? 2'h2 : 2'h1)) else $error("link outputs wrong");
  a_term_follow: assert property (wr_en_in && addr_in == ADDR_DRIVER |->
    ##2 termination_out == wd2[5:4]) else $error("termination wrong");
  a_term_wins: assert property (term_cnt >= 5'h10 |->
    !fco_double_out && !dco_double_out) else $error("double drive with termination");
  a_pulldown_follow: assert property (wr_en_in && addr_in == ADDR_PULLDOWN |->
    ##2 pulldown_off_out == wd2[0]) else $error("pull-down output wrong");
  a_refpwr_follow: assert property (wr_en_in && addr_in == ADDR_REFPWR |->
    ##2 vcm_pdwn_out == wd2[3]) else $error("reference power-down wrong");
  a_override_hold: assert property ($changed(rate_out) || $changed(res_out) ||
    $changed(chip_pdwn_out) |-> $past(wr_xfer, 2) || $past(srst_in) ||
    $past(srst_in, 2) || $past(srst_in, 3)) else $error("override moved early");
  a_digital_reset: assert property (wr_en_in && addr_in == ADDR_POWER &&
    wdata_in[1:0] == PWR_RESET |-> ##2 dp_reset_out) else $error("no datapath reset");
  a_phase_range: assert property (out_phase_out <= OUTPH_MAX)
    else $error("output phase out of range");
  a_open_zero: assert property (rd_en_in && addr_in == ADDR_LINK |=> rvalid_out &&
    (rdata_out & ~MASK_LINK) == 8'h00) else $error("open bits read nonzero");
  cover property (wr_xfer);
  cover property (fco_double_out && dco_double_out);
  cover property (chip_pdwn_out);
endmodule
bind output_ctrl_regs output_ctrl_checker i_output_ctrl_checker (.*);

//--- cfg_host.sv
`timescale 1ns/10ps
// Host on the configuration port; issues one-cycle register requests.
module cfg_host
  import cfg_pkg::*;
(
  input  wire logic                       clk_in,
  input  wire logic [cfg_pkg::DATA_W-1:0] rdata_in,
  input  wire logic                       rvalid_in,
  output logic                            wr_en_out,
  output logic                            rd_en_out,
  output logic      [cfg_pkg::ADDR_W-1:0] addr_out,
  output logic      [cfg_pkg::DATA_W-1:0] wdata_out
);
  logic [2:0] divider;  // Last divider ratio written, limits the input phase.
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 9'h000;
    wdata_out = 8'h00;
    divider = 3'h0;
  end
  // Writes one register; released lines show inverted values, never stale ones.
  task automatic write(input logic [8:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == ADDR_DIVIDER) divider = d[2:0];
    if (a == ADDR_PHASE && d[6:4] > divider) v[6:4] = divider;
    @(posedge clk_in);
    #1;
    addr_out = a;
    wdata_out = v;
    wr_en_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_en_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~v;
  endtask
  // Reads one register and takes the data in its valid cycle.
  task automatic read(input logic [8:0] a, output logic [7:0] d);
    int n;
    @(posedge clk_in);
    #1;
    addr_out = a;
    rd_en_out = 1'b1;
    @(posedge clk_in);
    #1;
    rd_en_out = 1'b0;
    addr_out = ~a;
    n = 0;
    while (rvalid_in !== 1'b1 && n < 4) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    d = (rvalid_in === 1'b1) ? rdata_in : 8'hXX;
  endtask
  // Re-runs the power-on setup once the clock is known to be stable.
  task automatic reinit();
    write(ADDR_POWER, 8'h03);
    write(ADDR_POWER, 8'h00);
  endtask
endmodule

//--- output_ctrl_regs_bench.sv
`timescale 1ns/10ps
// Drives the register bank through the host model and checks its outputs.
module output_ctrl_regs_bench;
  import cfg_pkg::*;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] wdata_in, rdata_out, rd;
  logic [2:0]        grade_rate_in, in_phase_out, rate_out;
  logic [1:0]        grade_res_in, termination_out, drive_current_out, res_out;
  logic [3:0]        out_phase_out;
  logic              clk_in, srst_in, wr_en_in, rd_en_in, rvalid_out, chop_en_out;
  logic              reduced_link_out, invert_out, twos_comp_out, fco_double_out;
  logic              dco_double_out, chip_pdwn_out, pulldown_off_out, vcm_pdwn_out;
  logic              dp_reset_out, init_busy_out;
  int                failures, checks_done, cycles;
  logic [8:0] addrs [10] = '{ADDR_INDEX, ADDR_DIVIDER, ADDR_ENHANCE, ADDR_LINK, ADDR_DRIVER,
    ADDR_PHASE, ADDR_OVERRIDE, ADDR_PULLDOWN, ADDR_REFPWR, 9'h00D};
  logic [7:0] masks [10] = '{MASK_INDEX, MASK_DIVIDER, MASK_ENHANCE, MASK_LINK, MASK_DRIVER,
    MASK_PHASE, MASK_OVERRIDE, MASK_PULLDOWN, MASK_REFPWR, 8'h00};
  output_ctrl_regs i_output_ctrl_regs (.*);
  cfg_host i_cfg_host (.clk_in(clk_in), .rdata_in(rdata_out), .rvalid_in(rvalid_out),
    .wr_en_out(wr_en_in), .rd_en_out(rd_en_in), .addr_out(addr_in), .wdata_out(wdata_in));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard.
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic expect8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Writes a register, then lets the given number of edges pass.
  task automatic put(input logic [8:0] a, input logic [7:0] d, input int n);
    i_cfg_host.write(a, d);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic peek(input logic [8:0] a, input logic [7:0] exp);
    i_cfg_host.read(a, rd);
    expect8(rd, exp);
  endtask
  // Waits for the setup sequence to finish, bounded.
  task automatic wait_init();
    int n;
    n = 0;
    while (init_busy_out !== 1'b0 && n < 100) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    repeat (3) @(posedge clk_in);
    #1;
    expect8({6'h00, dp_reset_out, init_busy_out}, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    srst_in = 1'b1;
    grade_rate_in = 3'h2;
    grade_res_in = RES_12;
    failures = 0;
    checks_done = 0;
    cycles = 0;
    repeat (4) @(posedge clk_in);
    #1;
    srst_in = 1'b0;
    expect8({3'h0, twos_comp_out, out_phase_out}, 8'h13);
    expect8({5'h00, init_busy_out, drive_current_out}, 8'h05);
    peek(ADDR_LINK, RST_LINK);
    peek(ADDR_PHASE, RST_PHASE);
    wait_init();
    // Every bank register but the power mode register, and one unmapped place, all ones written.
    for (int i = 0; i < 10; i++) begin
      put(addrs[i], 8'hFF, 0);
      peek(addrs[i], masks[i]);
    end
    repeat (17) @(posedge clk_in);
    #1;
    expect8({chop_en_out, pulldown_off_out, vcm_pdwn_out, fco_double_out, out_phase_out},
      8'hE3);
    expect8({rate_out, res_out, 2'h0, chip_pdwn_out}, 8'h50);
    put(ADDR_ENHANCE, 8'hFB, 1);
    expect8({7'h00, chop_en_out}, 8'h00);
    put(ADDR_PULLDOWN, 8'hFE, 0);
    put(ADDR_REFPWR, 8'hF7, 1);
    expect8({6'h00, pulldown_off_out, vcm_pdwn_out}, 8'h00);
    // Link options, then open bits only.
    put(ADDR_LINK, 8'h44, 1);
    expect8({3'h0, reduced_link_out, invert_out, twos_comp_out, drive_current_out},
      8'h1A);
    put(ADDR_LINK, 8'hBA, 1);
    expect8({3'h0, reduced_link_out, invert_out, twos_comp_out, drive_current_out},
      8'h01);
    peek(ADDR_LINK, 8'h00);
    // Clock driver strength against termination.
    put(ADDR_INDEX, 8'h30, 0);
    put(ADDR_DRIVER, 8'h21, 20);
    expect8({2'h0, termination_out, 2'h0, fco_double_out, dco_double_out}, 8'h20);
    put(ADDR_DRIVER, 8'h01, 17);
    expect8({6'h00, fco_double_out, dco_double_out}, 8'h03);
    put(ADDR_INDEX, 8'h10, 17);
    expect8({6'h00, fco_double_out, dco_double_out}, 8'h01);
    put(ADDR_DRIVER, 8'h00, 17);
    expect8({6'h00, fco_double_out, dco_double_out}, 8'h00);
    // Clock phases, with an out-of-range output code.
    put(ADDR_DIVIDER, 8'h07, 0);
    put(ADDR_PHASE, 8'h5B, 17);
    expect8({1'b0, in_phase_out, out_phase_out}, 8'h5B);
    put(ADDR_PHASE, 8'h0C, 17);
    expect8({1'b0, in_phase_out, out_phase_out}, 8'h0B);
    // Override waits for the transfer strobe; upgrades power the chip down.
    put(ADDR_OVERRIDE, 8'h61, 3);
    expect8({rate_out, res_out, 2'h0, chip_pdwn_out}, 8'h50);
    put(ADDR_TRANSFER, 8'h01, 1);
    expect8({rate_out, res_out, 2'h0, chip_pdwn_out}, 8'h30);
    put(ADDR_OVERRIDE, 8'h63, 0);
    put(ADDR_TRANSFER, 8'h01, 1);
    expect8({7'h00, chip_pdwn_out}, 8'h01);
    put(ADDR_OVERRIDE, 8'h51, 0);
    put(ADDR_TRANSFER, 8'h01, 1);
    expect8({7'h00, chip_pdwn_out}, 8'h01);
    put(ADDR_OVERRIDE, 8'h00, 0);
    put(ADDR_TRANSFER, 8'h01, 1);
    expect8({rate_out, res_out, 2'h0, chip_pdwn_out}, 8'h50);
    // Digital reset through the power mode register.
    i_cfg_host.reinit();
    expect8({6'h00, dp_reset_out, init_busy_out}, 8'h03);
    wait_init();
    summarize();
  end
endmodule
